// ### bench/testbench.sv
`timescale 1ns/1ps
`include "acz_consts.svh"
`define CHK(nm, ex, got) \
    begin \
        compares++; \
        if ((got) !== (ex)) \
        begin \
            mismatches++; \
            $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
        end \
    end
module testbench;
    import acz_pkg::*;
    localparam logic [9:0] A_PWR = {`ACZ_IDX_PWR, 2'b00};
    localparam logic [9:0] A_CTL = {`ACZ_IDX_CTL, 2'b00};
    localparam logic [9:0] A_MOD = {`ACZ_IDX_MOD, 2'b00};
    logic sys_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic cmp_raw, power_down_state, cmp_filter_sel_hi, timer3_overflow_tick, cmp_irq_enable;
    logic cmp_irq_req, cmp_wake, cmp_result, cmp_analog_en, cmp_low_power_en, int_ref_enable;
    logic neg_ref_pin, neg_use_int_ref, neg_ref_low_range;
    logic [1:0] pos_input_select;
    logic [4:0] neg_ladder_tap;
    logic [2:0] t3_cnt;
    int mismatches = 0;
    int compares = 0;

    acz_ctrl i_acz_ctrl (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmp_raw(cmp_raw),
        .power_down_state(power_down_state), .cmp_filter_sel_hi(cmp_filter_sel_hi),
        .timer3_overflow_tick(timer3_overflow_tick), .cmp_irq_enable(cmp_irq_enable),
        .cmp_irq_req(cmp_irq_req), .cmp_wake(cmp_wake), .cmp_result(cmp_result),
        .cmp_analog_en(cmp_analog_en), .cmp_low_power_en(cmp_low_power_en),
        .int_ref_enable(int_ref_enable), .pos_input_select(pos_input_select),
        .neg_ref_pin(neg_ref_pin), .neg_use_int_ref(neg_use_int_ref),
        .neg_ref_low_range(neg_ref_low_range), .neg_ladder_tap(neg_ladder_tap)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Timer 3 overflow stand-in: one pulse every five cycles
    always @(posedge sys_clk)
    begin
        t3_cnt <= (t3_cnt == 3'h4) ? 3'h0 : t3_cnt + 3'h1;
        timer3_overflow_tick <= (t3_cnt == 3'h4);
    end

    task finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wait_ack;
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        if (avs_waitrequest !== 1'b0)
        begin
            mismatches++;
            $display("[FAIL] avs_waitrequest expected 0 seen %h", avs_waitrequest);
            finish_test();
        end
    endtask

    task automatic bus_wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        wait_ack();
        d = avs_readdata[7:0];
        `CHK("readdata upper", 24'h00_0000, avs_readdata[31:8])
        avs_read <= 1'b0;
    endtask

    // Waits for the filtered result to settle, bounded
    task automatic wait_res(input logic v, input int b);
        int n;
        n = 0;
        while (cmp_result !== v && n < b)
        begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("cmp_result settle", v, cmp_result)
        if (cmp_result !== v)
            finish_test();
    endtask

    task automatic t_regs;
        logic [7:0] d;
        bus_rd(A_PWR, d);
        `CHK("pwr reset", 8'h00, d)
        bus_rd(A_CTL, d);
        `CHK("ctl reset", 8'h00, d)
        bus_rd(A_MOD, d);
        `CHK("mod reset", 8'h00, d)
        `CHK("neg_ref_pin reset", 1'b1, neg_ref_pin)
        bus_wr(A_PWR, 8'h80, 4'h1);
        bus_rd(A_PWR, d);
        `CHK("pwr readback", 8'h80, d)
        `CHK("int_ref_enable", 1'b1, int_ref_enable)
        bus_wr(A_PWR, 8'h00, 4'h1);
        tick(1);
        `CHK("int_ref_enable off", 1'b0, int_ref_enable)
        bus_wr(A_CTL, 8'hE7, 4'h0);
        bus_rd(A_CTL, d);
        `CHK("ctl lane off", 8'h00, d)
        bus_wr(A_CTL, 8'hE7, 4'h1);
        bus_rd(A_CTL, d);
        `CHK("ctl readback", 8'hC7, d)
        `CHK("cmp_low_power_en", 1'b1, cmp_low_power_en)
        bus_wr(10'h3FC, 8'h5A, 4'h1);
        bus_rd(10'h3FC, d);
        `CHK("unmapped", 8'h00, d)
        bus_wr(A_CTL, 8'h00, 4'h1);
        $display("test regs done");
    endtask

    task automatic t_ref;
        logic [3:0] c;
        logic lr;
        logic [7:0] d;
        for (int i = 0; i < 32; i++)
        begin
            c = i[3:0];
            lr = i[4];
            bus_wr(A_MOD, {c, lr, 1'b0, c[1:0]}, 4'h1);
            tick(2);
            `CHK("neg_ref_pin", (!lr && c == 4'h0), neg_ref_pin)
            `CHK("neg_use_int_ref", (lr && c == 4'h0), neg_use_int_ref)
            `CHK("tap", (c == 4'h0) ? 5'h00 : {1'b0, c} + (lr ? 5'h00 : 5'h08), neg_ladder_tap)
            `CHK("pos_input_select", c[1:0], pos_input_select)
            `CHK("neg_ref_low_range", lr, neg_ref_low_range)
            bus_rd(A_MOD, d);
            `CHK("mod readback", {c, lr, 1'b0, c[1:0]}, d)
        end
        bus_wr(A_MOD, 8'h00, 4'h1);
        $display("test ref done");
    endtask

    task automatic t_edge;
        logic [7:0] cv;
        logic [7:0] d;
        for (int e = 0; e < 4; e++)
        begin
            cv = {6'h02, e[1:0]};
            bus_wr(A_CTL, cv, 4'h1);
            tick(3);
            cmp_raw <= 1'b1;
            tick(6);
            bus_rd(A_CTL, d);
            `CHK("flag on rise", cv | {2'b00, 1'b1, e[1], 4'h0}, d)
            `CHK("cmp_irq_req", e[1], cmp_irq_req)
            bus_wr(A_CTL, cv, 4'h1);
            cmp_raw <= 1'b0;
            tick(6);
            bus_rd(A_CTL, d);
            `CHK("flag on fall", cv | {3'b000, e[0], 4'h0}, d)
        end
        cmp_irq_enable <= 1'b0;
        tick(20);
        `CHK("irq masked", 1'b0, cmp_irq_req)
        bus_rd(A_CTL, d);
        `CHK("flag held", 8'h1B, d)
        cmp_irq_enable <= 1'b1;
        // Clearing write lands on the very edge at which the rise event sets the flag
        bus_wr(A_CTL, 8'h0A, 4'h1);
        tick(4);
        cmp_raw <= 1'b1;
        bus_wr(A_CTL, 8'h0A, 4'h1);
        bus_rd(A_CTL, d);
        `CHK("set beats clear", 8'h3A, d)
        cmp_raw <= 1'b0;
        $display("test edge done");
    endtask

    task automatic t_inv_dis;
        logic [7:0] d;
        bus_wr(A_CTL, 8'h0E, 4'h1);
        tick(5);
        `CHK("inverted low", 1'b1, cmp_result)
        cmp_raw <= 1'b1;
        tick(5);
        `CHK("inverted high", 1'b0, cmp_result)
        cmp_raw <= 1'b0;
        tick(5);
        bus_wr(A_CTL, 8'h05, 4'h1);
        tick(3);
        `CHK("disabled result", 1'b0, cmp_result)
        `CHK("disabled analog", 1'b0, cmp_analog_en)
        cmp_raw <= 1'b1;
        tick(5);
        cmp_raw <= 1'b0;
        tick(5);
        bus_rd(A_CTL, d);
        `CHK("no event disabled", 8'h05, d)
        $display("test invert done");
    endtask

    // A one-cycle glitch never gathers three agreeing samples
    task automatic filt_case(input logic hi, input logic lo, input int w);
        bus_wr(A_MOD, {5'h00, lo, 2'b00}, 4'h1);
        cmp_filter_sel_hi <= hi;
        bus_wr(A_CTL, 8'h0A, 4'h1);
        tick(w);
        cmp_raw <= 1'b1;
        @(posedge sys_clk);
        cmp_raw <= 1'b0;
        tick(w);
        `CHK("glitch rejected", 1'b0, cmp_result)
        cmp_raw <= 1'b1;
        wait_res(1'b1, w);
        cmp_raw <= 1'b0;
        wait_res(1'b0, w);
    endtask

    task automatic t_filter;
        filt_case(1'b0, 1'b1, 8);
        filt_case(1'b1, 1'b0, 30);
        filt_case(1'b1, 1'b1, 30);
        cmp_filter_sel_hi <= 1'b0;
        bus_wr(A_MOD, 8'h00, 4'h1);
        $display("test filter done");
    endtask

    task automatic t_power;
        bus_wr(A_CTL, 8'h0A, 4'h1);
        power_down_state <= 1'b1;
        tick(3);
        `CHK("gated in power-down", 1'b0, cmp_analog_en)
        cmp_raw <= 1'b1;
        tick(5);
        `CHK("gated result", 1'b0, cmp_result)
        bus_wr(A_CTL, 8'h4A, 4'h1);
        tick(5);
        `CHK("keep running", 1'b1, cmp_analog_en)
        `CHK("wake on level", 1'b1, cmp_wake)
        tick(10);
        `CHK("wake held", 1'b1, cmp_wake)
        cmp_raw <= 1'b0;
        tick(5);
        `CHK("wake dropped", 1'b0, cmp_wake)
        power_down_state <= 1'b0;
        bus_wr(A_CTL, 8'h00, 4'h1);
        $display("test power done");
    endtask

    initial
    begin
        rst = 1'b1;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        cmp_raw = 1'b0;
        power_down_state = 1'b0;
        cmp_filter_sel_hi = 1'b0;
        timer3_overflow_tick = 1'b0;
        cmp_irq_enable = 1'b1;
        t3_cnt = 3'h0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_ref();
        t_edge();
        t_inv_dis();
        t_filter();
        t_power();
        finish_test();
    end
endmodule

// ### logic/acz_consts.svh
`ifndef ACZ_CONSTS_SVH
`define ACZ_CONSTS_SVH
// Register indices; byte address is four times the index
`define ACZ_IDX_PWR 8'h45
`define ACZ_IDX_CTL 8'h9E
`define ACZ_IDX_MOD 8'h9F
`define ACZ_RST_BYTE 8'h00
// Control/status bit positions
`define ACZ_CTL_LP 7
`define ACZ_CTL_KEEP 6
`define ACZ_CTL_RES 5
`define ACZ_CTL_FLAG 4
`define ACZ_CTL_EN 3
`define ACZ_CTL_INV 2
`define ACZ_CTL_EDGE_HI 1
`define ACZ_CTL_EDGE_LO 0
// Mode bit positions
`define ACZ_MOD_REF_HI 7
`define ACZ_MOD_REF_LO 4
`define ACZ_MOD_LOWR 3
`define ACZ_MOD_FLT 2
`define ACZ_MOD_PIS_HI 1
`define ACZ_MOD_PIS_LO 0
// Power control bit position
`define ACZ_PWR_IREF 7
// Ladder tap offset of the high range
`define ACZ_HI_RANGE_OFS 5'h08
`define ACZ_REF_PIN_CODE 4'h0
// Filter clock divider: tick every 6 cycles
`define ACZ_DIV_LAST 3'h5
`define ACZ_DIV_ZERO 3'h0
`define ACZ_DIV_ONE 3'h1
`endif

// ### logic/acz_ctrl.sv
// How it works
// [RULE_01] Result bit is read-only, writes ignored
// [RULE_02] Result is comparison, complemented when inverted
// [RULE_03] Edge field: 01 fall, 10 rise, 11 both
// [RULE_04] Selected edge while enabled sets event flag
// [RULE_05] Only software clears the event flag
// [RULE_06] Disabled: output forced low, no events
// [RULE_07] Outside enable bit masks the interrupt request
// [RULE_08] Power-down gates comparator unless keep-running set
// [RULE_09] Power-down wake uses level detection only; in both-edge mode the code wakes on filt differing from prev
// [RULE_10] Low-power bit selects comparator low power mode
// [RULE_11] High range: 0000 pin, else (code+8)/32
// [RULE_12] Control/status register bit layout
// [RULE_13] Mode register layout, cleared at reset
// [RULE_14] Positive input chosen among four pins
// [RULE_15] Sampling filter with three sample rates
// [RULE_16] Power control bit 7 enables internal reference
// [RULE_17] Software writes zeros to reserved power bits
// [RULE_18] Low range: 0000 internal ref, else code/24
// [RULE_19] Filter: off, or 3 agreeing samples
// [RULE_20] Positive select codes route pins 0..3
// [RULE_21] Edge from registered output versus previous cycle
// [RULE_22] Clear by writing 0; hardware set wins
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "acz_consts.svh"
module acz_ctrl (
    input wire logic sys_clk, // 125 MHz clock
    input wire logic rst, // Async reset, high
    input wire logic [9:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic cmp_raw, // Analog compare, V+ > V-
    input wire logic power_down_state, // CPU in power-down
    input wire logic cmp_filter_sel_hi, // Filter bit held elsewhere
    input wire logic timer3_overflow_tick, // Timer 3 overflow pulse
    input wire logic cmp_irq_enable, // Outside interrupt enable
    output logic cmp_irq_req, // Interrupt request level
    output logic cmp_wake, // Power-down wake request
    output logic cmp_result, // Filtered result
    output logic cmp_analog_en, // Comparator powered
    output logic cmp_low_power_en, // Low power mode
    output logic int_ref_enable, // Internal reference on
    output logic [1:0] pos_input_select, // V+ pin select
    output logic neg_ref_pin, // V- from pin
    output logic neg_use_int_ref, // V- from internal reference
    output logic neg_ref_low_range, // Ladder in 24ths, else 32nds
    output logic [4:0] neg_ladder_tap // Ladder numerator
);
    import acz_pkg::*;

    acz_state_s st_q;
    acz_state_s st_d;

    function automatic logic reg_hit(input logic [9:0] a, input logic [7:0] idx);
        reg_hit = (a[1:0] == 2'b00) && (a[9:2] == idx);
    endfunction

    function automatic logic edge_hit(input acz_edge_e m, input logic p, input logic c);
        unique case (m)
            ACZ_EDGE_FALL: edge_hit = p && !c;
            ACZ_EDGE_RISE: edge_hit = !p && c;
            ACZ_EDGE_BOTH: edge_hit = p != c;
            ACZ_EDGE_RSVD: edge_hit = 1'b0;
        endcase
    endfunction

    logic eff_en;
    logic raw_inv;
    logic tick;
    logic evt;
    logic lvl_ok;
    logic [2:0] samp_n;
    logic [7:0] ctl_rd;
    logic [7:0] mod_rd;
    logic [7:0] wb;
    acz_flt_e flt_mode;

    always_comb
    begin
        st_d = st_q;
        wb = avs_writedata[7:0];
        flt_mode = acz_flt_e'({cmp_filter_sel_hi, st_q.flt_lo});
        eff_en = st_q.en && !(power_down_state && !st_q.keep); // [RULE_08]
        raw_inv = cmp_raw ^ st_q.inv; // [RULE_02]
        // Divider runs free so the slow rate has a steady phase
        if (st_q.div == `ACZ_DIV_LAST)
        begin
            st_d.div = `ACZ_DIV_ZERO;
        end
        else
        begin
            st_d.div = st_q.div + `ACZ_DIV_ONE;
        end
        unique case (flt_mode) // [RULE_19] [RULE_15]
            ACZ_FLT_OFF: tick = 1'b0;
            ACZ_FLT_CLK: tick = 1'b1;
            ACZ_FLT_DIV6: tick = st_q.div == `ACZ_DIV_LAST;
            ACZ_FLT_T3: tick = timer3_overflow_tick;
        endcase
        samp_n = {st_q.samp[1:0], raw_inv};
        if (flt_mode == ACZ_FLT_OFF)
        begin
            st_d.samp = {3{raw_inv}};
            st_d.filt = raw_inv;
        end
        else if (tick)
        begin
            st_d.samp = samp_n;
            // Output moves only when three samples agree
            if (samp_n == 3'b111 || samp_n == 3'b000) // [RULE_19]
            begin
                st_d.filt = raw_inv;
            end
        end
        st_d.result = eff_en && st_q.filt; // [RULE_06]
        st_d.prev = st_q.result; // [RULE_21]
        evt = eff_en && edge_hit(st_q.edge_sel, st_q.prev, st_q.result); // [RULE_21] [RULE_03]

        ctl_rd = {st_q.lp, st_q.keep, st_q.result, st_q.flag,
                  st_q.en, st_q.inv, st_q.edge_sel}; // [RULE_12]
        mod_rd = {st_q.ref_sel, st_q.low_range, st_q.flt_lo, st_q.pis}; // [RULE_13]

        unique case (st_q.bus)
            ACZ_BUS_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    st_d.bus = ACZ_BUS_ACK;
                    st_d.waitreq = 1'b0;
                    if (reg_hit(avs_address, `ACZ_IDX_CTL))
                    begin
                        st_d.rdata = ctl_rd;
                    end
                    else if (reg_hit(avs_address, `ACZ_IDX_MOD))
                    begin
                        st_d.rdata = mod_rd;
                    end
                    else if (reg_hit(avs_address, `ACZ_IDX_PWR))
                    begin
                        st_d.rdata = {st_q.iref_en, 7'h00};
                    end
                    else
                    begin
                        st_d.rdata = `ACZ_RST_BYTE;
                    end
                end
            end
            ACZ_BUS_ACK:
            begin
                st_d.bus = ACZ_BUS_IDLE;
                st_d.waitreq = 1'b1;
                if (avs_write && avs_byteenable[0])
                begin
                    if (reg_hit(avs_address, `ACZ_IDX_CTL)) // [RULE_12]
                    begin
                        // Result bit has no storage behind it
                        st_d.lp = wb[`ACZ_CTL_LP]; // [RULE_10] [RULE_01]
                        st_d.keep = wb[`ACZ_CTL_KEEP];
                        st_d.flag = wb[`ACZ_CTL_FLAG]; // [RULE_22]
                        st_d.en = wb[`ACZ_CTL_EN];
                        st_d.inv = wb[`ACZ_CTL_INV];
                        st_d.edge_sel = acz_edge_e'(wb[`ACZ_CTL_EDGE_HI:`ACZ_CTL_EDGE_LO]);
                    end
                    if (reg_hit(avs_address, `ACZ_IDX_MOD)) // [RULE_13]
                    begin
                        st_d.ref_sel = wb[`ACZ_MOD_REF_HI:`ACZ_MOD_REF_LO];
                        st_d.low_range = wb[`ACZ_MOD_LOWR];
                        st_d.flt_lo = wb[`ACZ_MOD_FLT];
                        st_d.pis = wb[`ACZ_MOD_PIS_HI:`ACZ_MOD_PIS_LO]; // [RULE_14] [RULE_20]
                    end
                    if (reg_hit(avs_address, `ACZ_IDX_PWR))
                    begin
                        // Reserved bits are dropped whatever is written
                        st_d.iref_en = wb[`ACZ_PWR_IREF]; // [RULE_16] [RULE_17]
                    end
                end
            end
        endcase
        // Hardware event after the software write, so the set wins
        if (evt)
        begin
            st_d.flag = 1'b1; // [RULE_04] [RULE_22] [RULE_05]
        end

        st_d.irq = st_d.flag && cmp_irq_enable; // [RULE_07]
        st_d.ana_en = eff_en; // [RULE_08]
        // Edge logic may sleep in power-down, so wake looks at the level in fall and rise modes; both-edge compares filt with prev
        unique case (st_q.edge_sel)
            ACZ_EDGE_FALL: lvl_ok = !st_q.filt;
            ACZ_EDGE_RISE: lvl_ok = st_q.filt;
            ACZ_EDGE_BOTH: lvl_ok = st_q.filt != st_q.prev;
            ACZ_EDGE_RSVD: lvl_ok = 1'b0;
        endcase
        st_d.wake = power_down_state && st_q.en && st_q.keep
                    && cmp_irq_enable && lvl_ok; // [RULE_09]
        st_d.use_pin = !st_q.low_range && st_q.ref_sel == `ACZ_REF_PIN_CODE; // [RULE_11]
        st_d.use_iref = st_q.low_range && st_q.ref_sel == `ACZ_REF_PIN_CODE; // [RULE_18]
        if (st_q.ref_sel == `ACZ_REF_PIN_CODE)
        begin
            st_d.tap = 5'h00;
        end
        else if (st_q.low_range)
        begin
            st_d.tap = {1'b0, st_q.ref_sel}; // [RULE_18]
        end
        else
        begin
            st_d.tap = {1'b0, st_q.ref_sel} + `ACZ_HI_RANGE_OFS; // [RULE_11]
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= '0;
            st_q.waitreq <= 1'b1;
            st_q.bus <= ACZ_BUS_IDLE;
            st_q.use_pin <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign avs_readdata = {24'h00_0000, st_q.rdata};
    assign avs_waitrequest = st_q.waitreq;
    assign cmp_irq_req = st_q.irq;
    assign cmp_wake = st_q.wake;
    assign cmp_result = st_q.result;
    assign cmp_analog_en = st_q.ana_en;
    assign cmp_low_power_en = st_q.lp;
    assign int_ref_enable = st_q.iref_en;
    assign pos_input_select = st_q.pis;
    assign neg_ref_pin = st_q.use_pin;
    assign neg_use_int_ref = st_q.use_iref;
    assign neg_ref_low_range = st_q.low_range;
    assign neg_ladder_tap = st_q.tap;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_result_readonly: assert property ( // [RULE_01]
        avs_write && !avs_waitrequest && reg_hit(avs_address, `ACZ_IDX_CTL)
        && avs_writedata[`ACZ_CTL_RES] && !st_q.filt |=> !cmp_result)
        else $error("result bit changed by write");
    a_disabled_low: assert property ( // [RULE_06]
        !st_q.en |=> !cmp_result)
        else $error("result high while disabled");
    a_no_evt_off: assert property ( // [RULE_06]
        !st_q.en && !st_q.flag && !(avs_write && !avs_waitrequest) |=> !st_q.flag)
        else $error("flag set while disabled");
    a_rise_sets: assert property ( // [RULE_04]
        st_q.en && !power_down_state && st_q.edge_sel == ACZ_EDGE_RISE
        && !st_q.prev && st_q.result |=> st_q.flag)
        else $error("rising edge lost");
    a_rsvd_quiet: assert property ( // [RULE_03]
        st_q.edge_sel == ACZ_EDGE_RSVD && !st_q.flag
        && !(avs_write && !avs_waitrequest) |=> !st_q.flag)
        else $error("reserved mode set flag");
    a_flag_sticky: assert property ( // [RULE_05]
        st_q.flag && !(avs_write && !avs_waitrequest) |=> st_q.flag)
        else $error("flag dropped without write");
    a_irq_mask: assert property ( // [RULE_07]
        st_q.flag && cmp_irq_enable && !(avs_write && !avs_waitrequest) |=> cmp_irq_req)
        else $error("irq not passed");
    a_irq_block: assert property ( // [RULE_07]
        !cmp_irq_enable |=> !cmp_irq_req)
        else $error("irq not masked");
    a_sleep_gate: assert property ( // [RULE_08]
        power_down_state && !st_q.keep |=> !cmp_analog_en)
        else $error("comparator not gated in power-down");
    a_wake_cond: assert property ( // [RULE_09]
        cmp_wake |-> $past(power_down_state) && $past(st_q.keep) && $past(st_q.en))
        else $error("wake without conditions");
    a_hi_tap: assert property ( // [RULE_11]
        !st_q.low_range && st_q.ref_sel != `ACZ_REF_PIN_CODE && $stable(st_q.ref_sel)
        && $stable(st_q.low_range)
        |=> neg_ladder_tap == {1'b0, $past(st_q.ref_sel)} + `ACZ_HI_RANGE_OFS)
        else $error("high range tap wrong");
    a_lo_iref: assert property ( // [RULE_18]
        st_q.low_range && st_q.ref_sel == `ACZ_REF_PIN_CODE && $stable(st_q.ref_sel)
        && $stable(st_q.low_range) |=> neg_use_int_ref && !neg_ref_pin)
        else $error("internal reference not chosen");
    a_filt_three: assert property ( // [RULE_19]
        flt_mode == ACZ_FLT_CLK && $stable(flt_mode) && st_q.filt != raw_inv
        && st_q.samp[1:0] != {2{raw_inv}} |=> st_q.filt == $past(st_q.filt))
        else $error("filter moved on one sample");
    a_set_wins: assert property ( // [RULE_22]
        evt |=> st_q.flag)
        else $error("event lost against clear");
    a_bus_ack: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer in one cycle");

    c_flag_set: cover property (!st_q.flag ##1 st_q.flag);
    c_flag_clear: cover property (st_q.flag ##1 !st_q.flag);
    c_wake: cover property (cmp_wake);
    c_div6: cover property (flt_mode == ACZ_FLT_DIV6 && st_q.filt != $past(st_q.filt));
endmodule

// ### logic/acz_pkg.sv
package acz_pkg;
    typedef enum logic [1:0] {
        ACZ_EDGE_RSVD = 2'b00,
        ACZ_EDGE_FALL = 2'b01,
        ACZ_EDGE_RISE = 2'b10,
        ACZ_EDGE_BOTH = 2'b11
    } acz_edge_e;
    typedef enum logic [1:0] {
        ACZ_FLT_OFF = 2'b00,
        ACZ_FLT_CLK = 2'b01,
        ACZ_FLT_DIV6 = 2'b10,
        ACZ_FLT_T3 = 2'b11
    } acz_flt_e;
    typedef enum logic {
        ACZ_BUS_IDLE = 1'b0,
        ACZ_BUS_ACK = 1'b1
    } acz_bus_e;
    typedef struct packed {
        logic iref_en;
        logic lp;
        logic keep;
        logic flag;
        logic en;
        logic inv;
        acz_edge_e edge_sel;
        logic [3:0] ref_sel;
        logic low_range;
        logic flt_lo;
        logic [1:0] pis;
        logic [2:0] samp;
        logic [2:0] div;
        logic filt;
        logic result;
        logic prev;
        logic irq;
        logic wake;
        logic ana_en;
        logic use_pin;
        logic use_iref;
        logic [4:0] tap;
        acz_bus_e bus;
        logic waitreq;
        logic [7:0] rdata;
    } acz_state_s;
endpackage
